// >>> pkg/i2cse_pkg.sv
package i2cse_pkg;
    // ----------------------------------------
    // clocking and timing
    // ----------------------------------------
    localparam int CLK_HZ              = 125_000_000;                  // mclk rate
    localparam int I2C_HZ              = 100_000;                      // scl rate
    localparam int QTR_CYCLES          = CLK_HZ / (4 * I2C_HZ);        // quarter bit
    localparam int USEC_CYCLES         = CLK_HZ / 1_000_000;           // one microsecond
    localparam int FREE_TIMEOUT_S      = 1;                            // bus free wait, s
    localparam int FREE_TIMEOUT_CYCLES = CLK_HZ * FREE_TIMEOUT_S;      // bus free wait
    localparam int BUS_IDLE_NS         = 4700;                         // idle time, ns
    localparam int BUS_IDLE_CYCLES     = (BUS_IDLE_NS * USEC_CYCLES + 999) / 1000;

    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int PORTS   = 2;                                        // bus ports
    localparam int CMD_AW  = 6;                                        // script words
    localparam int RES_AW  = 4;                                        // read results
    localparam int DATA_AW = 8;                                        // result bytes
    localparam int TMO_W   = 27;                                       // timeout counter

    // ----------------------------------------
    // port value after reset and nak flag values
    // ----------------------------------------
    localparam logic [7:0] PORT_RST  = 8'h00;                          // default port
    localparam logic       NAK_FINAL_TRUE  = 1'b1;                     // nak last byte
    localparam logic       NAK_FINAL_FALSE = 1'b0;                     // ack last byte

    // ----------------------------------------
    // command and status types
    // ----------------------------------------
    typedef enum logic [2:0] {
        CMD_ISSUE_START,
        CMD_ISSUE_STOP,
        CMD_READ_BYTES,
        CMD_WRITE_BYTES,
        CMD_MICRO_DELAY
    } i2cse_op_t;

    typedef enum logic [2:0] {
        ERR_NONE,
        ERR_TIMEOUT,
        ERR_NAK,
        ERR_BAD_COUNT,
        ERR_BAD_PORT,
        ERR_BAD_OP
    } i2cse_err_t;

    typedef struct packed {
        i2cse_op_t   op;                                               // command kind
        logic        nakFinalByteFlag;                                 // read: nak last
        logic [15:0] arg;                                              // count/us/byte
    } i2cse_cmd_t;

    typedef struct packed {
        logic       busy;                                              // script running
        logic       done;                                              // one-cycle end
        logic       error;                                             // last run failed
        i2cse_err_t code;                                              // failure cause
    } i2cse_status_t;

    localparam i2cse_status_t STATUS_RST = '{1'b0, 1'b0, 1'b0, ERR_NONE};
endpackage

// >>> design/i2cse_engine.sv
module i2cse_engine #(
    parameter int TIMEOUT_CYCLES = i2cse_pkg::FREE_TIMEOUT_CYCLES
) (
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          sys_rst,
    // script loading
    input  wire logic                          cmdLoadValid,
    input  wire i2cse_pkg::i2cse_cmd_t         cmdLoadWord,
    input  wire logic                          cmdClearScript,
    output logic [i2cse_pkg::RES_AW-1:0]       readResultIndex,
    output logic                               scriptFull,
    // script run
    input  wire logic                          cmdExecuteScript,
    input  wire logic [7:0]                    busPortSelect,
    output i2cse_pkg::i2cse_status_t           status,
    // result readback
    input  wire logic [i2cse_pkg::RES_AW-1:0]  resultIndex,
    input  wire logic [15:0]                   resultByte,
    output logic [15:0]                        resultCount,
    output logic [7:0]                         resultData,
    // open-drain bus pins
    input  wire logic [i2cse_pkg::PORTS-1:0]   sclIn,
    input  wire logic [i2cse_pkg::PORTS-1:0]   sdaIn,
    output logic [i2cse_pkg::PORTS-1:0]        sclOut,
    output logic [i2cse_pkg::PORTS-1:0]        sclOe,
    output logic [i2cse_pkg::PORTS-1:0]        sdaOut,
    output logic [i2cse_pkg::PORTS-1:0]        sdaOe
);
    localparam int CW = i2cse_pkg::CMD_AW;
    localparam int RW = i2cse_pkg::RES_AW;
    localparam int DW = i2cse_pkg::DATA_AW;
    localparam int PN = i2cse_pkg::PORTS;
    localparam int TMO_LOCAL = i2cse_pkg::TMO_W;

    // ----------------------------------------
    // storage
    // ----------------------------------------
    i2cse_pkg::i2cse_cmd_t cmdMem [2**CW];                 // script words
    logic [7:0]            dataMem [2**DW];                // received bytes
    logic [DW-1:0]         resBase [2**RW];                // first byte per read
    logic [15:0]           resLen [2**RW];                 // byte count per read

    // enable mask for the running port
    function automatic logic [PN-1:0] portMask(input logic [7:0] sel, input logic drv);
        portMask = '0;
        for (int i = 0; i < PN; i++) begin
            if (sel == 8'(i)) begin
                portMask[i] = drv;
            end
        end
    endfunction

    // ack bit for a read byte: low acks, high naks
    function automatic logic readAckBit(input logic [15:0] left, input logic nak);
        readAckBit = (left == 16'h0001) && (nak == i2cse_pkg::NAK_FINAL_TRUE);
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [PN-1:0] sclS1_reg;                              // first stage
    logic [PN-1:0] sclS2_reg;                              // second stage
    logic [PN-1:0] sdaS1_reg;                              // first stage
    logic [PN-1:0] sdaS2_reg;                              // second stage

    // two flops per pin
    always_ff @(posedge mclk) begin
        sclS1_reg <= sclIn;
        sclS2_reg <= sclS1_reg;
        sdaS1_reg <= sdaIn;
        sdaS2_reg <= sdaS1_reg;
    end

    // ----------------------------------------
    // engine state
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE, ST_FETCH, ST_WAITFREE, ST_START, ST_XFER, ST_STOP, ST_DELAY, ST_FINISH
    } i2cse_state_t;

    i2cse_state_t             state_reg, state_next;      // sequencer
    i2cse_pkg::i2cse_cmd_t    cur_reg, cur_next;          // command in flight
    logic [CW-1:0]            pc_reg, pc_next;            // next script word
    logic [CW:0]              loadPtr_reg, loadPtr_next;  // words loaded
    logic [RW-1:0]            loadReads_reg, loadReads_next;
    logic [RW-1:0]            readNum_reg, readNum_next;  // reads executed
    logic [DW-1:0]            dataPtr_reg, dataPtr_next;  // next result byte
    logic [7:0]               sel_reg, sel_next;          // running port
    logic [15:0]              remain_reg, remain_next;    // bytes or us left
    logic [1:0]               phase_reg, phase_next;      // quarter of a bit
    logic [3:0]               bitCnt_reg, bitCnt_next;    // bit of a byte
    logic [8:0]               shift_reg, shift_next;      // out and in bits
    logic [TMO_LOCAL-1:0]     tmo_reg, tmo_next;          // bus-free wait
    logic [15:0]              idle_reg, idle_next;        // bus idle time
    logic [8:0]               qDiv_reg, qDiv_next;        // quarter divider
    logic [7:0]               uDiv_reg, uDiv_next;        // microsecond divider
    logic                     owned_reg, owned_next;      // we hold the bus
    logic                     sclDrv_reg, sclDrv_next;    // pull scl low
    logic                     sdaDrv_reg, sdaDrv_next;    // pull sda low
    i2cse_pkg::i2cse_status_t status_reg, status_next;
    logic                     cmdWe, dataWe, resWe;       // memory writes
    logic                     qTick, uTick, sclS, sdaS;

    assign qTick = (qDiv_reg == 9'(i2cse_pkg::QTR_CYCLES - 1));
    assign uTick = (uDiv_reg == 8'(i2cse_pkg::USEC_CYCLES - 1));
    assign sclS  = sclS2_reg[sel_reg[0]];
    assign sdaS  = sdaS2_reg[sel_reg[0]];

    // next-state logic for the sequencer
    always_comb begin
        state_next = state_reg;  cur_next = cur_reg;  pc_next = pc_reg;
        loadPtr_next = loadPtr_reg;  loadReads_next = loadReads_reg;
        readNum_next = readNum_reg;  dataPtr_next = dataPtr_reg;  sel_next = sel_reg;
        remain_next = remain_reg;  phase_next = phase_reg;  bitCnt_next = bitCnt_reg;
        shift_next = shift_reg;  owned_next = owned_reg;
        sclDrv_next = sclDrv_reg;  sdaDrv_next = sdaDrv_reg;
        status_next = status_reg;  status_next.done = 1'b0;
        tmo_next = tmo_reg + 1'b1;
        qDiv_next = qTick ? '0 : qDiv_reg + 1'b1;
        uDiv_next = uTick ? '0 : uDiv_reg + 1'b1;
        idle_next = '0;                                    // any low line restarts
        if (sclS && sdaS && !owned_reg) begin
            // saturate once free, only while both lines stay high
            idle_next = (idle_reg == 16'(i2cse_pkg::BUS_IDLE_CYCLES)) ? idle_reg
                                                                      : idle_reg + 16'h0001;
        end
        cmdWe = 1'b0;  dataWe = 1'b0;  resWe = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (cmdClearScript) begin
                    loadPtr_next = '0;  loadReads_next = '0;  readNum_next = '0;
                end else if (cmdExecuteScript) begin
                    sel_next = busPortSelect;  pc_next = '0;  readNum_next = '0;
                    dataPtr_next = '0;  status_next = i2cse_pkg::STATUS_RST;
                    status_next.busy = 1'b1;  state_next = ST_FETCH;
                    if (busPortSelect >= 8'(PN)) begin
                        status_next.code = i2cse_pkg::ERR_BAD_PORT;  state_next = ST_FINISH;
                    end
                end else if (cmdLoadValid && !loadPtr_reg[CW]) begin
                    cmdWe = 1'b1;  loadPtr_next = loadPtr_reg + 1'b1;
                    if (cmdLoadWord.op == i2cse_pkg::CMD_READ_BYTES) begin
                        loadReads_next = loadReads_reg + 1'b1;
                    end
                end
            end
            ST_FETCH: begin
                // one command at a time, in order
                cur_next = cmdMem[pc_reg];  pc_next = pc_reg + 1'b1;
                remain_next = cmdMem[pc_reg].arg;  phase_next = '0;  bitCnt_next = '0;
                tmo_next = '0;                             // clear per start
                if ({1'b0, pc_reg} == loadPtr_reg) begin
                    state_next = ST_FINISH;
                end else begin
                    case (cmdMem[pc_reg].op)
                        i2cse_pkg::CMD_ISSUE_START: state_next = ST_WAITFREE;
                        i2cse_pkg::CMD_ISSUE_STOP:  state_next = ST_STOP;
                        i2cse_pkg::CMD_MICRO_DELAY: state_next = ST_DELAY;
                        i2cse_pkg::CMD_READ_BYTES: begin
                            shift_next = {8'hff, readAckBit(cmdMem[pc_reg].arg,
                                                            cmdMem[pc_reg].nakFinalByteFlag)};
                            state_next = ST_XFER;
                            resWe = (cmdMem[pc_reg].arg != 16'h0000);
                        end
                        i2cse_pkg::CMD_WRITE_BYTES: begin
                            shift_next = {cmdMem[pc_next].arg[7:0], 1'b1};
                            pc_next = pc_reg + 6'(2);
                            state_next = ST_XFER;
                        end
                        default: begin
                            status_next.code = i2cse_pkg::ERR_BAD_OP;  state_next = ST_FINISH;
                        end
                    endcase
                    if ((cmdMem[pc_reg].op == i2cse_pkg::CMD_READ_BYTES ||
                         cmdMem[pc_reg].op == i2cse_pkg::CMD_WRITE_BYTES) &&
                        cmdMem[pc_reg].arg == 16'h0000) begin
                        status_next.code = i2cse_pkg::ERR_BAD_COUNT;  state_next = ST_FINISH;
                    end
                end
            end
            ST_WAITFREE: begin
                if (owned_reg || idle_reg == 16'(i2cse_pkg::BUS_IDLE_CYCLES)) begin
                    state_next = ST_START;                 // bus free, or already ours for a restart
                end else if (tmo_reg == TMO_LOCAL'(TIMEOUT_CYCLES - 1)) begin
                    status_next.code = i2cse_pkg::ERR_TIMEOUT;  state_next = ST_FINISH;
                end
            end
            ST_START: begin
                if (qTick) begin
                    phase_next = phase_reg + 1'b1;
                    case (phase_reg)
                        2'd0: sdaDrv_next = 1'b0;
                        2'd1: sclDrv_next = 1'b0;
                        2'd2: sdaDrv_next = 1'b1;
                        default: begin
                            sclDrv_next = 1'b1;  owned_next = 1'b1;  state_next = ST_FETCH;
                        end
                    endcase
                end
            end
            ST_XFER: begin
                if (qTick) begin
                    phase_next = phase_reg + 1'b1;
                    case (phase_reg)
                        2'd0: sdaDrv_next = !shift_reg[8];
                        2'd1: sclDrv_next = 1'b0;
                        2'd2: begin
                            if (sclS) begin                // wait out clock stretching
                                shift_next = {shift_reg[7:0], sdaS};
                            end else begin
                                phase_next = phase_reg;
                            end
                        end
                        default: begin
                            sclDrv_next = 1'b1;  bitCnt_next = bitCnt_reg + 1'b1;
                            if (bitCnt_reg == 4'd8) begin
                                bitCnt_next = '0;  remain_next = remain_reg - 1'b1;
                                sdaDrv_next = 1'b0;
                                if (cur_reg.op == i2cse_pkg::CMD_WRITE_BYTES) begin
                                    shift_next = {cmdMem[pc_reg].arg[7:0], 1'b1};
                                    pc_next = pc_reg + 1'b1;
                                    if (shift_reg[0]) begin
                                        status_next.code = i2cse_pkg::ERR_NAK;
                                        state_next = ST_FINISH;
                                    end else if (remain_reg == 16'h0001) begin
                                        pc_next = pc_reg;  state_next = ST_FETCH;
                                    end
                                end else begin
                                    // keep byte for its read index
                                    dataWe = 1'b1;  dataPtr_next = dataPtr_reg + 1'b1;
                                    shift_next = {8'hff, readAckBit(remain_next,
                                                                    cur_reg.nakFinalByteFlag)};
                                    if (remain_reg == 16'h0001) begin
                                        readNum_next = readNum_reg + 1'b1;
                                        state_next = ST_FETCH;
                                    end
                                end
                            end
                        end
                    endcase
                end
            end
            ST_STOP: begin
                if (qTick) begin
                    phase_next = phase_reg + 1'b1;
                    case (phase_reg)
                        2'd0: sdaDrv_next = 1'b1;
                        2'd1: sclDrv_next = 1'b0;
                        2'd2: sdaDrv_next = 1'b0;
                        default: begin
                            owned_next = 1'b0;  state_next = ST_FETCH;
                        end
                    endcase
                end
            end
            ST_DELAY: begin
                if (remain_reg == 16'h0000) begin
                    state_next = ST_FETCH;
                end else if (uTick) begin
                    remain_next = remain_reg - 1'b1;
                end
            end
            ST_FINISH: begin
                // error ends run and frees bus
                status_next.busy = 1'b0;  status_next.done = 1'b1;
                status_next.error = (status_reg.code != i2cse_pkg::ERR_NONE);
                if (status_reg.code != i2cse_pkg::ERR_NONE) begin
                    sclDrv_next = 1'b0;  sdaDrv_next = 1'b0;  owned_next = 1'b0;
                end
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // register the sequencer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;  cur_reg <= '0;  pc_reg <= '0;  loadPtr_reg <= '0;
            loadReads_reg <= '0;  readNum_reg <= '0;  dataPtr_reg <= '0;
            sel_reg <= i2cse_pkg::PORT_RST;  remain_reg <= '0;  phase_reg <= '0;
            bitCnt_reg <= '0;  shift_reg <= '0;  tmo_reg <= '0;  idle_reg <= '0;
            qDiv_reg <= '0;  uDiv_reg <= '0;  owned_reg <= 1'b0;
            sclDrv_reg <= 1'b0;  sdaDrv_reg <= 1'b0;  status_reg <= i2cse_pkg::STATUS_RST;
        end else begin
            state_reg <= state_next;  cur_reg <= cur_next;  pc_reg <= pc_next;
            loadPtr_reg <= loadPtr_next;  loadReads_reg <= loadReads_next;
            readNum_reg <= readNum_next;  dataPtr_reg <= dataPtr_next;  sel_reg <= sel_next;
            remain_reg <= remain_next;  phase_reg <= phase_next;  bitCnt_reg <= bitCnt_next;
            shift_reg <= shift_next;  tmo_reg <= tmo_next;  idle_reg <= idle_next;
            qDiv_reg <= qDiv_next;  uDiv_reg <= uDiv_next;  owned_reg <= owned_next;
            sclDrv_reg <= sclDrv_next;  sdaDrv_reg <= sdaDrv_next;  status_reg <= status_next;
        end
    end

    // memory writes
    always_ff @(posedge mclk) begin
        if (cmdWe) begin
            cmdMem[loadPtr_reg[CW-1:0]] <= cmdLoadWord;
        end
        if (dataWe) begin
            dataMem[dataPtr_reg] <= shift_reg[8:1];
        end
        if (resWe) begin
            resBase[readNum_reg] <= dataPtr_reg;
            resLen[readNum_reg] <= cmdMem[pc_reg].arg;
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sclOe <= '0;  sdaOe <= '0;  sclOut <= '0;  sdaOut <= '0;
            readResultIndex <= '0;  scriptFull <= 1'b0;  resultCount <= '0;
            resultData <= '0;
        end else begin
            sclOe <= portMask(sel_next, sclDrv_next);
            sdaOe <= portMask(sel_next, sdaDrv_next);
            sclOut <= '0;                                  // open drain: low only
            sdaOut <= '0;
            readResultIndex <= loadReads_next - 1'b1;      // index of last read loaded
            scriptFull <= loadPtr_next[CW];
            // readback; cleared results read as empty
            resultCount <= (resultIndex < readNum_reg) ? resLen[resultIndex] : 16'h0000;
            resultData <= dataMem[DW'(resBase[resultIndex] + resultByte[DW-1:0])];
        end
    end

    assign status = status_reg;
endmodule

// >>> sim/i2cse_chk.sv
module i2cse_chk #(
    parameter int TIMEOUT_CYCLES = 2000
) (
    input wire logic                     mclk,
    input wire logic                     sys_rst,
    input wire logic                     cmdClearScript,
    input wire logic                     cmdExecuteScript,
    input wire logic [7:0]               busPortSelect,
    input wire i2cse_pkg::i2cse_status_t status,
    input wire logic [3:0]               readResultIndex,
    input wire logic                     scriptFull,
    input wire logic [1:0]               sclIn,
    input wire logic [1:0]               sclOe,
    input wire logic [1:0]               sdaOe
);
    logic [31:0] busyCnt_reg;  // cycles busy so far
    logic [31:0] busyCnt_next;
    always_comb busyCnt_next = status.busy ? busyCnt_reg + 32'h1 : 32'h0;
    always_ff @(posedge mclk) busyCnt_reg <= sys_rst ? 32'h0 : busyCnt_next;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    run_taken_a: assert property (
        !status.busy && cmdExecuteScript && !cmdClearScript |=> status.busy)
        else $error("run not taken");
    done_pulse_a: assert property (status.done |=> !status.done)
        else $error("done too long");
    done_idle_a: assert property (status.done |-> !status.busy)
        else $error("busy at done");
    lines_free_a: assert property (
        !status.busy && !$past(status.busy) && !status.done |-> (sclOe | sdaOe) == 2'h0)
        else $error("pins held idle");
    port_only_a: assert property (
        status.busy && busPortSelect < 8'h02 |->
        ((sclOe | sdaOe) & ~(2'h1 << busPortSelect[0])) == 2'h0)
        else $error("wrong port driven");
    start_free_a: assert property ($rose(sdaOe[0]) && !sclOe[0] |-> sclIn[0])
        else $error("start on busy bus");
    tmo_len_a: assert property (
        status.done && status.code == i2cse_pkg::ERR_TIMEOUT |->
        busyCnt_reg >= TIMEOUT_CYCLES && busyCnt_reg <= TIMEOUT_CYCLES + 700)
        else $error("timeout length");
    code_hold_a: assert property (
        !status.busy && !cmdExecuteScript |=> $stable(status.code))
        else $error("code changed");
    clear_empty_a: assert property (
        cmdClearScript && !status.busy |=> readResultIndex == 4'hf && !scriptFull)
        else $error("clear left data");
    cover property (status.done && !status.error);
    cover property (status.done && status.code == i2cse_pkg::ERR_TIMEOUT);
    cover property (cmdClearScript && !status.busy);
endmodule
bind i2cse_engine i2cse_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (.mclk(mclk), .sys_rst(sys_rst),
    .cmdClearScript(cmdClearScript), .cmdExecuteScript(cmdExecuteScript),
    .busPortSelect(busPortSelect), .status(status), .readResultIndex(readResultIndex),
    .scriptFull(scriptFull), .sclIn(sclIn), .sclOe(sclOe), .sdaOe(sdaOe));

// >>> sim/i2cse_target.sv
module i2cse_target (
    // bus lines, byte to send
    input wire logic       scl,
    input wire logic       sda,
    input wire logic [7:0] dataByte,
    // sda pull, master ninth-bit tally
    output logic           sdaPull,
    output int             ackCnt,
    output int             nakCnt
);
    timeunit 1ns;
    timeprecision 1ps;
    int bitPos = 8;
    bit active = 1'b0;
    initial sdaPull = 1'b0;
    initial ackCnt = 0;
    initial nakCnt = 0;
    // start or restart rewinds; stop ends sending
    always @(negedge sda) if (scl) {active, bitPos} = {1'b1, 32'd8};
    always @(posedge sda) if (scl) active = 1'b0;
    // msb first while scl low, ninth slot left free
    always @(negedge scl) begin
        bitPos = (bitPos == 8) ? 0 : bitPos + 1;
        sdaPull <= active && bitPos < 8 && !dataByte[7 - bitPos];
    end
    // tally ack or nak; a nak ends sending
    always @(posedge scl) if (bitPos == 8 && active) begin
        if (sda) nakCnt++;
        else ackCnt++;
        active = !sda;
    end
endmodule

// >>> sim/i2cse_engine_bench.sv
module i2cse_engine_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, sys_rst = 1'b1, cmdLoadValid = 1'b0, cmdClearScript = 1'b0;
    logic cmdExecuteScript = 1'b0, holdScl = 1'b0, scriptFull, sdaPull;
    logic [7:0] busPortSelect = 8'h00, dataByte = 8'h00, resultData;
    logic [3:0] resultIndex = 4'h0, readResultIndex;
    logic [15:0] resultByte = 16'h0000, resultCount;
    logic [1:0] sclOe, sdaOe, sclW, sdaW;
    i2cse_pkg::i2cse_cmd_t cmdLoadWord = '0;
    i2cse_pkg::i2cse_status_t status;
    int ackCnt, nakCnt, failures = 0, check_count = 0;
    // pulled-up open-drain wires; port 1 scl can be held low
    assign sclW = ~(sclOe | {holdScl, 1'b0});
    assign sdaW = ~(sdaOe | {1'b0, sdaPull});
    always #4 mclk = ~mclk;
    i2cse_engine #(.TIMEOUT_CYCLES(2000)) dut (.mclk(mclk), .sys_rst(sys_rst),
        .cmdLoadValid(cmdLoadValid), .cmdLoadWord(cmdLoadWord), .cmdClearScript(cmdClearScript),
        .readResultIndex(readResultIndex), .scriptFull(scriptFull),
        .cmdExecuteScript(cmdExecuteScript), .busPortSelect(busPortSelect), .status(status),
        .resultIndex(resultIndex), .resultByte(resultByte), .resultCount(resultCount),
        .resultData(resultData), .sclIn(sclW), .sdaIn(sdaW), .sclOut(), .sclOe(sclOe),
        .sdaOut(), .sdaOe(sdaOe));
    i2cse_target tgt (.scl(sclW[0]), .sda(sdaW[0]), .dataByte(dataByte), .sdaPull(sdaPull),
        .ackCnt(ackCnt), .nakCnt(nakCnt));
    task automatic check(input logic [15:0] seen, input logic [15:0] expd);
        check_count++;
        if (seen !== expd) begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic load(input i2cse_pkg::i2cse_op_t op, input logic nak, input logic [15:0] arg);
        @(posedge mclk);
        cmdLoadValid <= 1'b1;
        cmdLoadWord <= '{op, nak, arg};
        @(posedge mclk);
        cmdLoadValid <= 1'b0;
    endtask
    task automatic pulse(input logic clr);
        @(posedge mclk);
        {cmdClearScript, cmdExecuteScript} <= {clr, !clr};
        @(posedge mclk);
        {cmdClearScript, cmdExecuteScript} <= 2'b00;
        #1;
    endtask
    task automatic run(input logic [7:0] port, input i2cse_pkg::i2cse_err_t code);
        int n;
        busPortSelect <= port;
        pulse(1'b0);
        for (n = 0; n < 80000 && status.done !== 1'b1; n++) @(posedge mclk) #1;
        if (n == 80000) failures++;
        if (n == 80000) print_verdict();
        check(status.error, code != i2cse_pkg::ERR_NONE);
        check(status.code, code);
    endtask
    task automatic peek(input logic [3:0] idx, input logic [15:0] cnt);
        @(posedge mclk);
        {resultIndex, resultByte} <= {idx, cnt - 16'h1};
        repeat (2) @(posedge mclk);
        #1;
        check(resultCount, cnt);
        if (cnt != 0) check(resultData, dataByte);
    endtask
    initial begin
        int n, m;
        void'($urandom(32'h00a5671d));
        n = $urandom_range(2, 1);
        m = $urandom_range(2, 1);
        dataByte = $urandom;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk) #1;
        check(status, i2cse_pkg::STATUS_RST);
        // start before reads, stop closes, port 0
        load(i2cse_pkg::CMD_ISSUE_START, 1'b0, 16'h0000);
        load(i2cse_pkg::CMD_READ_BYTES, i2cse_pkg::NAK_FINAL_FALSE, n);
        load(i2cse_pkg::CMD_READ_BYTES, i2cse_pkg::NAK_FINAL_TRUE, m);
        load(i2cse_pkg::CMD_ISSUE_START, 1'b0, 16'h0000);
        load(i2cse_pkg::CMD_READ_BYTES, i2cse_pkg::NAK_FINAL_TRUE, 16'h0001);
        load(i2cse_pkg::CMD_ISSUE_STOP, 1'b0, 16'h0000);
        @(posedge mclk) #1;
        check(readResultIndex, 16'h0002);
        run(8'h00, i2cse_pkg::ERR_NONE);
        check(ackCnt, n + m - 1);
        check(nakCnt, 16'h0002);
        peek(4'h0, n);
        peek(4'h1, m);
        peek(4'h2, 16'h0001);
        pulse(1'b1);
        peek(4'h1, 16'h0000);
        load(i2cse_pkg::CMD_ISSUE_START, 1'b0, 16'h0000);
        load(i2cse_pkg::CMD_READ_BYTES, 1'b1, 16'h0001);
        holdScl <= 1'b1;
        run(8'h01, i2cse_pkg::ERR_TIMEOUT);
        peek(4'h0, 16'h0000);
        holdScl <= 1'b0;
        run(8'h02, i2cse_pkg::ERR_BAD_PORT);
        // delay, then a one-byte write whose ninth bit the target leaves free
        pulse(1'b1);
        load(i2cse_pkg::CMD_MICRO_DELAY, 1'b0, 16'h0001);
        load(i2cse_pkg::CMD_ISSUE_START, 1'b0, 16'h0000);
        load(i2cse_pkg::CMD_WRITE_BYTES, 1'b0, 16'h0001);
        load(i2cse_pkg::CMD_WRITE_BYTES, 1'b0, {8'h00, dataByte});
        run(8'h00, i2cse_pkg::ERR_NAK);
        check(nakCnt, 16'h0003);
        pulse(1'b1);
        load(i2cse_pkg::CMD_ISSUE_START, 1'b0, 16'h0000);
        load(i2cse_pkg::CMD_READ_BYTES, 1'b1, 16'h0000);
        run(8'h00, i2cse_pkg::ERR_BAD_COUNT);
        print_verdict();
    end
endmodule
